// ---- nrg_far_side.sv ----
// Far-side model: the network master that owns command word 32.
// Assumes the bench asks for enable and sync toggles one cycle at a time.

`timescale 1ns/1ps
`default_nettype none

module nrg_far_side (
	input wire logic clk,
	input wire logic rst,
	input wire logic enReq,
	input wire logic toggleReq,
	output logic [15:0] cmdWord
);
	logic pendReg;

	// The enable is raised before the sync bit is inverted.
	// The inversion waits a cycle so the enable is never late.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmdWord <= 16'h0000;
			pendReg <= 1'b0;
		end else begin
			cmdWord[14] <= enReq | toggleReq | pendReg;
			if (toggleReq) begin
				pendReg <= 1'b1;
			end else if (pendReg && cmdWord[14]) begin
				cmdWord[15] <= ~cmdWord[15];
				pendReg <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// ---- nrg_pkg.sv ----
// Constants shared by the network register transfer gating block.
// Assumes a single 125 MHz clock and a classic Wishbone register bus.

package nrg_pkg;

	// ********************************************************************
	// Timing.
	// ********************************************************************
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned SPEED_SCAN_MS = 20;
	localparam int unsigned PARAM_PASS_MS = 100;
	localparam int unsigned MINOR_SCAN_US = 1000;
	localparam int unsigned SPEED_SCAN_CYC = SPEED_SCAN_MS * CLK_KHZ;
	localparam int unsigned PARAM_PASS_CYC = PARAM_PASS_MS * CLK_KHZ;
	localparam int unsigned MINOR_SCAN_CYC = MINOR_SCAN_US * CLK_KHZ / 1000;

	// ********************************************************************
	// Drive word layout.
	// ********************************************************************
	localparam int unsigned CMD_WORD_IDX = 32;
	localparam int unsigned STAT_WORD_IDX = 0;
	localparam int unsigned CMD_ENABLE_BIT = 14;
	localparam int unsigned CMD_SYNC_BIT = 15;
	localparam int unsigned STAT_SYNC_BIT = 7;
	localparam int unsigned STAT_REJECT_BIT = 12;
	localparam logic [3:0] NET_SOURCE_CODE = 4'h3;

	// ********************************************************************
	// Register map, byte addresses.
	// ********************************************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;

	// Control register fields.
	localparam int unsigned CTRL_ONLY_BIT = 0;
	localparam int unsigned CTRL_TORQUE_BIT = 1;
	localparam int unsigned CTRL_SRC_LSB = 8;

	// Status register fields.
	localparam int unsigned ST_SYNC_BIT = 0;
	localparam int unsigned ST_REJECT_BIT = 1;
	localparam int unsigned ST_OPEN_BIT = 2;
	localparam int unsigned ST_TUNE_EN_BIT = 3;
	localparam int unsigned ST_RUN_BIT = 4;
	localparam int unsigned ST_HELD_BIT = 5;
	localparam int unsigned ST_FIRST_BIT = 6;

	// Interrupt event bits.
	localparam int unsigned IRQ_W = 4;
	localparam int unsigned EV_FAST = 0;
	localparam int unsigned EV_SLOW = 1;
	localparam int unsigned EV_REJECT = 2;
	localparam int unsigned EV_SYNC = 3;

endpackage

// ---- nrg_tick_gen.sv ----
// Free-running period divider that gives one pulse per scan period.
// Assumes a single clock; the period is a whole number of cycles.

`timescale 1ns/1ps
`default_nettype none

module nrg_tick_gen #(
	parameter int unsigned PERIOD = 2
) (
	input wire logic clk,
	input wire logic rst,
	output logic tick
);

	logic [31:0] count_reg;

	// Count up to the last cycle of the period, then wrap.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_reg <= 32'h0000_0000;
		end else if (tick) begin
			count_reg <= 32'h0000_0000;
		end else begin
			count_reg <= count_reg + 32'h0000_0001;
		end
	end

	// The pulse is decoded from the counter; it lasts one cycle.
	assign tick = (count_reg == 32'(PERIOD - 1));

endmodule

`default_nettype wire

// ---- nrg_transfer_gate.sv ----
// Transfer gating between the option board memory and the drive regulator.
// Assumes synchronous inputs on clk, a classic Wishbone master and a
// regulator that acts on the one-cycle transfer strobes this block issues.

`timescale 1ns/1ps
`default_nettype none

module nrg_transfer_gate #(
	parameter int unsigned FAST_CYC = nrg_pkg::SPEED_SCAN_CYC,
	parameter int unsigned SLOW_CYC = nrg_pkg::PARAM_PASS_CYC,
	parameter int unsigned MINOR_CYC = nrg_pkg::MINOR_SCAN_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic irq,
	input wire logic netActive,
	input wire logic driveRunning,
	input wire logic [15:0] cmdWord,
	input wire logic paramErrIn,
	output logic fastInputsMoved,
	output logic torqueRefMoved,
	output logic tuneInputsMoved,
	output logic configInputsMoved,
	output logic outputsMoved,
	output logic slowOutputsMoved,
	output logic syncReadBack,
	output logic paramRejectFlag
);

	// ********************************************************************
	// Helpers.
	// ********************************************************************

	// Merge write data into an old value under the byte enables.
	function automatic logic [31:0] mergeLanes(input logic [31:0] oldVal,
			input logic [31:0] newVal, input logic [3:0] sel);
		logic [31:0] res;
		res = oldVal;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = newVal[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// ********************************************************************
	// Scan timers.
	// ********************************************************************
	logic fastTick;
	logic slowTick;
	logic minorTick;

	nrg_tick_gen #(.PERIOD(FAST_CYC)) uFast (
		.clk(clk),
		.rst(rst),
		.tick(fastTick)
	);

	nrg_tick_gen #(.PERIOD(SLOW_CYC)) uSlow (
		.clk(clk),
		.rst(rst),
		.tick(slowTick)
	);

	nrg_tick_gen #(.PERIOD(MINOR_CYC)) uMinor (
		.clk(clk),
		.rst(rst),
		.tick(minorTick)
	);

	// ********************************************************************
	// Bus slave.
	// ********************************************************************
	logic ack_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] mask_reg;
	logic [nrg_pkg::IRQ_W-1:0] irqStat_reg;
	logic [nrg_pkg::IRQ_W-1:0] events;
	logic [31:0] statusWord;
	logic wrStrobe;
	logic [31:0] rdData;

	// The answer comes one cycle after the request and lasts one cycle.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= cyc_i & stb_i & ~ack_reg;
		end
	end

	assign ack_o = ack_reg;
	// A write lands on the edge where the master sees ack.
	assign wrStrobe = ack_reg & cyc_i & stb_i & we_i;

	// Read mux; unmapped addresses read as zero and still answer.
	always_comb begin
		unique case (adr_i)
			nrg_pkg::CTRL_OFS: rdData = ctrl_reg;
			nrg_pkg::STAT_OFS: rdData = statusWord;
			nrg_pkg::IRQ_STAT_OFS: rdData = {28'h000_0000, irqStat_reg};
			nrg_pkg::IRQ_MASK_OFS: rdData = mask_reg;
			default: rdData = 32'h0000_0000;
		endcase
	end

	// Read data is captured at the request edge so it is stable with ack.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dat_o <= 32'h0000_0000;
		end else if (cyc_i & stb_i & ~ack_reg) begin
			dat_o <= rdData;
		end
	end

	// Control and mask registers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= nrg_pkg::CTRL_RST;
			mask_reg <= nrg_pkg::IRQ_MASK_RST;
		end else if (wrStrobe) begin
			if (adr_i == nrg_pkg::CTRL_OFS) begin
				ctrl_reg <= mergeLanes(ctrl_reg, dat_i, sel_i);
			end
			if (adr_i == nrg_pkg::IRQ_MASK_OFS) begin
				mask_reg <= mergeLanes(mask_reg, dat_i, sel_i);
			end
		end
	end

	// Sticky events; a new event in the clearing cycle is kept.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irqStat_reg <= '0;
		end else begin
			if (wrStrobe && adr_i == nrg_pkg::IRQ_STAT_OFS && sel_i[0]) begin
				irqStat_reg <= (irqStat_reg & ~dat_i[nrg_pkg::IRQ_W-1:0])
						| events;
			end else begin
				irqStat_reg <= irqStat_reg | events;
			end
		end
	end

	assign irq = |(irqStat_reg & mask_reg[nrg_pkg::IRQ_W-1:0]);

	// ********************************************************************
	// Gating conditions.
	// ********************************************************************
	logic ctrlOnlyPoll;
	logic torqueFromPort;
	logic [3:0] ctrlSource;
	logic inputsOpen;
	logic tuneEnable;

	assign ctrlOnlyPoll = ctrl_reg[nrg_pkg::CTRL_ONLY_BIT];
	assign torqueFromPort = ctrl_reg[nrg_pkg::CTRL_TORQUE_BIT];
	assign ctrlSource = ctrl_reg[nrg_pkg::CTRL_SRC_LSB +: 4];

	// No input of any kind passes without an active network in command.
	assign inputsOpen = netActive & (ctrlSource == nrg_pkg::NET_SOURCE_CODE);
	// A control-only connection overrides whatever the master sends.
	assign tuneEnable = cmdWord[nrg_pkg::CMD_ENABLE_BIT] & ~ctrlOnlyPoll;

	// ********************************************************************
	// Transfer strobes.
	// ********************************************************************
	logic configHeld_reg;

	// Fast path: control/reference in and runtime outputs out each scan.
	// Outputs ignore every gate so the master always sees drive state.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fastInputsMoved <= 1'b0;
			outputsMoved <= 1'b0;
			torqueRefMoved <= 1'b0;
		end else begin
			fastInputsMoved <= fastTick & inputsOpen;
			outputsMoved <= fastTick;
			torqueRefMoved <= minorTick & inputsOpen & torqueFromPort;
		end
	end

	// Slow pass: tunables run or stopped, configuration only when stopped.
	// Each move replaces the regulator copy, so keypad edits are lost.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tuneInputsMoved <= 1'b0;
			configInputsMoved <= 1'b0;
			slowOutputsMoved <= 1'b0;
		end else begin
			tuneInputsMoved <= slowTick & inputsOpen & tuneEnable;
			configInputsMoved <= slowTick & inputsOpen & tuneEnable
					& ~driveRunning;
			slowOutputsMoved <= slowTick;
		end
	end

	// Remember configuration that was held back by a running drive.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			configHeld_reg <= 1'b0;
		end else if (slowTick & inputsOpen & tuneEnable) begin
			configHeld_reg <= driveRunning;
		end
	end

	// ********************************************************************
	// Loopback and rejection flag.
	// ********************************************************************
	logic firstPass_reg;

	// Both flags read zero until a pass has really been processed.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			firstPass_reg <= 1'b0;
		end else if (tuneInputsMoved) begin
			firstPass_reg <= 1'b1;
		end
	end

	// The echo is taken after the pass, also while running; the bit
	// steers nothing else in this block.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			syncReadBack <= 1'b0;
		end else if (tuneInputsMoved) begin
			syncReadBack <= cmdWord[nrg_pkg::CMD_SYNC_BIT];
		end
	end

	// The verdict of the regulator is only taken from enabled passes.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			paramRejectFlag <= 1'b0;
		end else if (tuneInputsMoved) begin
			paramRejectFlag <= paramErrIn;
		end
	end

	// Status word and interrupt sources.
	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[nrg_pkg::ST_SYNC_BIT] = syncReadBack;
		statusWord[nrg_pkg::ST_REJECT_BIT] = paramRejectFlag;
		statusWord[nrg_pkg::ST_OPEN_BIT] = inputsOpen;
		statusWord[nrg_pkg::ST_TUNE_EN_BIT] = tuneEnable;
		statusWord[nrg_pkg::ST_RUN_BIT] = driveRunning;
		statusWord[nrg_pkg::ST_HELD_BIT] = configHeld_reg;
		statusWord[nrg_pkg::ST_FIRST_BIT] = firstPass_reg;
		events = '0;
		events[nrg_pkg::EV_FAST] = outputsMoved;
		events[nrg_pkg::EV_SLOW] = slowOutputsMoved;
		events[nrg_pkg::EV_REJECT] = tuneInputsMoved & paramErrIn;
		events[nrg_pkg::EV_SYNC] = tuneInputsMoved;
	end

	// ********************************************************************
	// Checks.
	// ********************************************************************
	int unsigned fastGap;
	logic fastSeen;

	// Cycles since the last fast strobe, to check the scan period.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fastGap <= 0;
			fastSeen <= 1'b0;
		end else if (outputsMoved) begin
			fastGap <= 1;
			fastSeen <= 1'b1;
		end else begin
			fastGap <= fastGap + 1;
		end
	end

	chk_fast_period: assert property (@(posedge clk) disable iff (rst)
		(outputsMoved && fastSeen) |-> fastGap == FAST_CYC)
		else $error("fast scan period wrong");

	chk_torque_minor: assert property (@(posedge clk) disable iff (rst)
		torqueRefMoved |-> $past(minorTick) && $past(torqueFromPort))
		else $error("torque reference moved off its scan");

	chk_config_stop: assert property (@(posedge clk) disable iff (rst)
		configInputsMoved |-> !$past(driveRunning) && tuneInputsMoved)
		else $error("configuration moved while running");

	chk_outputs_free: assert property (@(posedge clk) disable iff (rst)
		fastTick |=> outputsMoved)
		else $error("output copy skipped");

	chk_gate_inputs: assert property (@(posedge clk) disable iff (rst)
		(fastInputsMoved || tuneInputsMoved) |-> $past(netActive)
			&& $past(ctrlSource) == nrg_pkg::NET_SOURCE_CODE)
		else $error("input moved with network not in control");

	chk_tune_enable: assert property (@(posedge clk) disable iff (rst)
		tuneInputsMoved |-> $past(cmdWord[nrg_pkg::CMD_ENABLE_BIT]))
		else $error("tunables moved without enable");

	chk_ctrl_only: assert property (@(posedge clk) disable iff (rst)
		$past(ctrlOnlyPoll) |-> !tuneInputsMoved)
		else $error("tunables moved on control-only poll");

	chk_sync_copy: assert property (@(posedge clk) disable iff (rst)
		tuneInputsMoved |=> syncReadBack == $past(cmdWord[nrg_pkg::CMD_SYNC_BIT]))
		else $error("write bit not echoed");

	chk_sync_cause: assert property (@(posedge clk) disable iff (rst)
		$changed(syncReadBack) |-> $past(tuneInputsMoved))
		else $error("echo changed outside a pass");

	chk_reject_cause: assert property (@(posedge clk) disable iff (rst)
		$changed(paramRejectFlag) |-> $past(tuneInputsMoved, 1))
		else $error("rejection flag changed outside a pass");

	chk_reject_copy: assert property (@(posedge clk) disable iff (rst)
		tuneInputsMoved |=> paramRejectFlag == $past(paramErrIn))
		else $error("rejection verdict not taken from the pass");

	chk_slow_outputs: assert property (@(posedge clk) disable iff (rst)
		slowTick |=> slowOutputsMoved)
		else $error("slow output copy skipped");

	chk_first_pass: assert property (@(posedge clk) disable iff (rst)
		!firstPass_reg |-> !syncReadBack && !paramRejectFlag)
		else $error("flags set before the first pass");

	cov_config_deferred: cover property (@(posedge clk) disable iff (rst)
		configHeld_reg ##1 configInputsMoved);
	cov_sync_echo: cover property (@(posedge clk) disable iff (rst)
		tuneInputsMoved && driveRunning ##1 $changed(syncReadBack));
	cov_reject_set: cover property (@(posedge clk) disable iff (rst)
		$rose(paramRejectFlag));
	cov_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));

endmodule

`default_nettype wire

// ---- test_network_register_transfer_gating.sv ----
// Self-checking bench for the transfer gating block.
// Assumes shortened scan counts of 20, 100 and 5 cycles.

`timescale 1ns/1ps
`default_nettype none

module test_network_register_transfer_gating;
	logic clk, rst, cyc, stb, we, ack, irq, netAct, run, err, enReq, tog;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] datW, datR, q;
	logic [15:0] cmdWord;
	logic fastM, torqM, tuneM, confM, outM, slowM, echo, rej, expEcho;
	int mismatches, n_compared, k;
	logic [31:0] cnt[6];
	logic [3:0] selUse;

	nrg_far_side nrg_far_side_i (.clk(clk), .rst(rst), .enReq(enReq),
		.toggleReq(tog), .cmdWord(cmdWord));

	nrg_transfer_gate #(.FAST_CYC(20), .SLOW_CYC(100), .MINOR_CYC(5))
	nrg_transfer_gate_i (.clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
		.ack_o(ack), .irq(irq), .netActive(netAct), .driveRunning(run),
		.cmdWord(cmdWord), .paramErrIn(err), .fastInputsMoved(fastM),
		.torqueRefMoved(torqM), .tuneInputsMoved(tuneM),
		.configInputsMoved(confM), .outputsMoved(outM),
		.slowOutputsMoved(slowM), .syncReadBack(echo),
		.paramRejectFlag(rej));

	// ********************************************************************
	// Clock and shared tasks.
	// ********************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic final_report();
		if (mismatches == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// One classic cycle; the answer is taken only at the edge with ack high.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		sel <= selUse;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (ack === 1'b1) break;
		end
		if (k == 20) begin
			chk(32'h1, 32'h0);
			final_report();
		end
		q = datR;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	// Counts every strobe over 200 cycles, a whole number of each period.
	task automatic win(input int f, t, u, c, o, s);
		repeat (3) @(posedge clk);
		cnt = '{0, 0, 0, 0, 0, 0};
		repeat (200) begin
			@(posedge clk);
			cnt[0] += fastM;
			cnt[1] += torqM;
			cnt[2] += tuneM;
			cnt[3] += confM;
			cnt[4] += outM;
			cnt[5] += slowM;
		end
		chk(cnt[0], f);
		chk(cnt[1], t);
		chk(cnt[2], u);
		chk(cnt[3], c);
		chk(cnt[4], o);
		chk(cnt[5], s);
	endtask

	task automatic toggle();
		@(posedge clk);
		tog <= 1'b1;
		expEcho = ~cmdWord[15];
		@(posedge clk);
		tog <= 1'b0;
	endtask

	// ********************************************************************
	// Main sequence.
	// ********************************************************************
	initial begin
		mismatches = 0;
		n_compared = 0;
		{cyc, stb, we, netAct, run, err, enReq, tog} = 8'h00;
		adr = 8'h00;
		sel = 4'h0;
		selUse = 4'hf;
		datW = 32'h0;
		rst = 1'b1;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({irq, echo, rej}, 3'h0);
		wb(1'b0, nrg_pkg::CTRL_OFS, 32'h0);
		chk(q, nrg_pkg::CTRL_RST);
		wb(1'b0, nrg_pkg::IRQ_MASK_OFS, 32'h0);
		chk(q, nrg_pkg::IRQ_MASK_RST);
		wb(1'b1, 8'h40, 32'hffff_ffff);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		win(0, 0, 0, 0, 10, 2);
		netAct <= 1'b1;
		wb(1'b1, nrg_pkg::CTRL_OFS, 32'h0000_0300);
		win(10, 0, 0, 0, 10, 2);
		wb(1'b1, nrg_pkg::CTRL_OFS, 32'h0000_0302);
		win(10, 40, 0, 0, 10, 2);
		wb(1'b1, nrg_pkg::CTRL_OFS, 32'h0000_0300);
		enReq <= 1'b1;
		win(10, 0, 2, 2, 10, 2);
		run <= 1'b1;
		win(10, 0, 2, 0, 10, 2);
		toggle();
		for (k = 0; k < 300 && echo !== expEcho; k++) @(posedge clk);
		chk(echo, expEcho);
		wb(1'b0, nrg_pkg::STAT_OFS, 32'h0);
		chk(q[nrg_pkg::ST_SYNC_BIT], expEcho);
		netAct <= 1'b0;
		win(0, 0, 0, 0, 10, 2);
		netAct <= 1'b1;
		run <= 1'b0;
		wb(1'b1, nrg_pkg::CTRL_OFS, 32'h0000_0301);
		win(10, 0, 0, 0, 10, 2);
		toggle();
		repeat (250) @(posedge clk);
		chk(echo, {31'h0, ~expEcho});
		wb(1'b1, nrg_pkg::CTRL_OFS, 32'h0000_0300);
		for (k = 0; k < 300 && echo !== expEcho; k++) @(posedge clk);
		chk(echo, expEcho);
		err <= 1'b1;
		for (k = 0; k < 300 && rej !== 1'b1; k++) @(posedge clk);
		chk(rej, 1'b1);
		enReq <= 1'b0;
		err <= 1'b0;
		repeat (250) @(posedge clk);
		chk(rej, 1'b1);
		enReq <= 1'b1;
		for (k = 0; k < 300 && rej !== 1'b0; k++) @(posedge clk);
		chk(rej, 1'b0);
		wb(1'b1, nrg_pkg::IRQ_MASK_OFS, 32'h0000_0002);
		for (k = 0; k < 300 && irq !== 1'b1; k++) @(posedge clk);
		chk(irq, 1'b1);
		for (k = 0; k < 300 && slowM !== 1'b1; k++) @(posedge clk);
		wb(1'b1, nrg_pkg::IRQ_STAT_OFS, 32'h0000_0002);
		wb(1'b0, nrg_pkg::IRQ_STAT_OFS, 32'h0);
		chk(q & 32'h2, 32'h0);
		chk(irq, 1'b0);
		// Only byte lane 0 may change: the source field must survive.
		selUse = 4'h1;
		wb(1'b1, nrg_pkg::CTRL_OFS, 32'hffff_ff01);
		selUse = 4'hf;
		wb(1'b0, nrg_pkg::CTRL_OFS, 32'h0);
		chk(q, 32'h0000_0301);
		final_report();
	end

	// A hang anywhere ends the run with a counted mismatch.
	initial begin
		repeat (20000) @(posedge clk);
		chk(32'h1, 32'h0);
		final_report();
	end
endmodule

`default_nettype wire
